/* hdl/scop_pkg.sv */
// constants and carrier types for the sampling converter output pipeline
// assumes one 25 MHz clock; analog levels arrive as unsigned digital levels
// Function
// RULE1: a sample taken each cycle shows on the outputs three edges later
// RULE2: output pins change only on a rising clock edge, from a register
// RULE3: previous output word stays valid until the next rising edge replaces it
// RULE4: one new conversion result reaches the outputs in every active cycle
// RULE5: code is unsigned straight binary spanning bottom to top reference; code is (level - bottom) >> STEP_SH, top only clamps
// RULE6: input below the bottom reference gives an all zero word
// RULE7: input above the top reference gives an all one word
// RULE8: conversion runs continuously while the clock runs and is enabled
// RULE9: conversion is active only while the sleep request is low
// RULE10: sleep request high holds the outputs at the last conversion
// RULE11: after wake, output words are flagged invalid for about one microsecond
// RULE12: with the clock stopped, the outputs keep the last code
// RULE13: receiver registers words on a rising edge after the output delay
package scop_pkg;

  // ************************************************************
  // widths and codes
  // ************************************************************
  localparam int              CODE_W    = 8;
  localparam int              LEVEL_W   = 12;
  localparam int              STEP_SH   = 4;    // levels per code step = 2**STEP_SH
  localparam logic [7:0]      CODE_ZERO = 8'h00;
  localparam logic [7:0]      CODE_FULL = 8'hff;
  localparam int              FIFO_DEPTH = 8;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int              CLK_PERIOD_NS = 40;
  localparam int              WAKE_NS       = 1000;
  localparam int              SETTLE_W      = 5;
  // least time: round up to whole cycles
  localparam logic [4:0]      WAKE_CYC      =
    SETTLE_W'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int              LATENCY       = 3;

  // one quantised result as it travels through the buffer
  typedef struct packed {
    logic              below;
    logic              above;
    logic [CODE_W-1:0] code;
  } scop_result_t;

endpackage : scop_pkg

/* hdl/scop_top.sv */
// output pipeline of an 8-bit sampling converter: capture, quantise, buffer, drive
// assumes sample level and references come from logic on sys_clk; sleep pin is async
`timescale 1ns/1ps

// ************************************************************
// buffer between quantiser and output driver
// ************************************************************
module scop_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1),
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic          clr,
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  wire logic          out_ready,
  output logic [CW-1:0]      count
);
  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  // handshakes; full and empty straight from the count
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // storage, written only on accepted pushes
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count; clear drops stale content on wake
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (clk_en && clr)) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 1'b1;
        2'b01:   cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule : scop_fifo

// ************************************************************
// converter output pipeline
// ************************************************************
module scop_top
  import scop_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic               sleep_request,
  input  wire logic [LEVEL_W-1:0] sample_level,
  input  wire logic [LEVEL_W-1:0] ladder_bottom_ref,
  input  wire logic [LEVEL_W-1:0] ladder_top_ref,
  output logic [CODE_W-1:0]       sample_code,
  output logic                    sample_valid,
  output logic                    low_power
);
  localparam int CW = $clog2(DEPTH + 1);

  logic               slp_s1_q;
  logic               slp_s2_q;
  logic               slp_s3_q;
  logic               sleep_q;
  logic               sleep_d;
  logic               flush;
  logic [LEVEL_W-1:0] level_q;
  logic               s0_vld_q;
  scop_result_t       res;
  scop_result_t       fifo_out;
  logic               in_ready;
  logic               out_valid;
  logic [CW-1:0]      fifo_cnt;
  logic               pop;
  logic               push;
  logic               loaded_q;
  logic [SETTLE_W-1:0] settle_q;

  // clamp and scale one level against the ladder
  function automatic scop_result_t quantize(input logic [LEVEL_W-1:0] lvl,
                                            input logic [LEVEL_W-1:0] bot,
                                            input logic [LEVEL_W-1:0] top);
    scop_result_t       r;
    logic [LEVEL_W-1:0] diff;
    diff    = lvl - bot;
    r.below = (lvl < bot);
    r.above = (lvl > top);
    r.code  = r.below ? CODE_ZERO :                  // RULE6
              r.above ? CODE_FULL :                  // RULE7
              diff[STEP_SH +: CODE_W];               // RULE5
    return r;
  endfunction : quantize

  // ************************************************************
  // sleep pin synchroniser: change taken once stages two and three agree
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slp_s1_q <= 1'b0;
      slp_s2_q <= 1'b0;
      slp_s3_q <= 1'b0;
      sleep_q  <= 1'b0;
    end else if (clk_en) begin
      slp_s1_q <= sleep_request;
      slp_s2_q <= slp_s1_q;
      slp_s3_q <= slp_s2_q;
      sleep_q  <= sleep_d;
    end
  end
  assign sleep_d = (slp_s2_q == slp_s3_q) ? slp_s2_q : sleep_q;   // RULE9
  // wake drops the buffered backlog so latency returns to three edges
  assign flush   = sleep_q && !sleep_d;

  // ************************************************************
  // capture stage: stalls only when the buffer is full
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level_q  <= '0;
      s0_vld_q <= 1'b0;
    end else if (clk_en) begin                                 // RULE12
      if (flush) begin
        s0_vld_q <= 1'b0;
      end else if (in_ready || !s0_vld_q) begin                 // RULE8
        level_q  <= sample_level;                               // RULE1
        s0_vld_q <= 1'b1;
      end
    end
  end

  assign res  = quantize(level_q, ladder_bottom_ref, ladder_top_ref);
  assign push = clk_en && s0_vld_q && in_ready && !flush;
  // drain halts while asleep, so the buffer fills and stalls capture
  assign pop  = clk_en && out_valid && !sleep_q;                // RULE10

  scop_fifo #(
    .W     ($bits(scop_result_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .clr       (flush),
    .in_valid  (s0_vld_q && !flush),
    .in_data   (res),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .out_data  (fifo_out),
    .out_ready (!sleep_q),
    .count     (fifo_cnt)
  );

  // ************************************************************
  // output driver: registered, so pins move only after a rising edge
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_code <= CODE_ZERO;
      loaded_q    <= 1'b0;
    end else if (clk_en) begin
      loaded_q <= pop;
      if (pop) begin
        sample_code <= fifo_out.code;                           // RULE2 RULE3 RULE4
      end
    end
  end

  // settle window after wake; words during it carry valid low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settle_q     <= '0;
      sample_valid <= 1'b0;
      low_power    <= 1'b0;
    end else if (clk_en) begin
      low_power <= sleep_d;
      if (flush) begin
        settle_q <= WAKE_CYC;                                   // RULE11
      end else if (settle_q != '0) begin
        settle_q <= settle_q - 1'b1;
      end
      sample_valid <= pop && (settle_q == '0) && !flush;        // RULE11
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_latency_three: assert property ( // RULE1
    $past(pop, 1) && $past(fifo_cnt == CW'(1), 1) && $past(push, 2) &&
    $past(clk_en && in_ready && !flush, 3) && $past(!flush, 1)
    |-> sample_code == $past(quantize(sample_level, ladder_bottom_ref,
                                      ladder_top_ref).code, LATENCY))
    else $error("output word does not match sample three edges back");
  chk_freeze_hold: assert property (!clk_en |=> $stable(sample_code)) // RULE12
    else $error("output moved while clock stopped");
  chk_sleep_hold: assert property (sleep_q && clk_en |=> $stable(sample_code)) // RULE10
    else $error("output moved while asleep");
  chk_stream_rate: assert property ( // RULE4
    (clk_en && !sleep_q && !flush && s0_vld_q) [*4] |-> loaded_q)
    else $error("no new word during steady conversion");
  chk_below_zero: assert property ( // RULE6
    push && level_q < ladder_bottom_ref |-> res.code == CODE_ZERO)
    else $error("under-range sample not all zeros");
  chk_above_ones: assert property ( // RULE7
    push && level_q > ladder_top_ref && level_q >= ladder_bottom_ref
    |-> res.code == CODE_FULL)
    else $error("over-range sample not all ones");
  chk_code_scale: assert property ( // RULE5
    push && !res.below && !res.above
    |-> ({4'h0, res.code} << STEP_SH) <= LEVEL_W'(level_q - ladder_bottom_ref)
        && (LEVEL_W'(level_q - ladder_bottom_ref) >> STEP_SH) == {4'h0, res.code})
    else $error("in-range code not straight binary");
  chk_wake_invalid: assert property ( // RULE11
    $fell(sleep_q) |-> !sample_valid [*8])
    else $error("word flagged valid inside wake settle window");
  chk_sync_agree: assert property ( // RULE9
    $changed(sleep_q) |-> $past(slp_s2_q == slp_s3_q))
    else $error("sleep taken before synchroniser stages agreed");
  chk_code_edge: assert property ( // RULE2
    $changed(sample_code) |-> $past(pop))
    else $error("output changed without a loaded word");

  cov_wake: cover property ($fell(sleep_q) ##[1:40] sample_valid);
  cov_clamp_low: cover property (push && res.below);
  cov_clamp_high: cover property (push && res.above);
  cov_fifo_full: cover property (fifo_cnt == CW'(DEPTH));
endmodule : scop_top

/* verif/scop_rx_model.sv */
// receiving logic model: registers each valid output word on a rising edge
// assumes sample_code and sample_valid are registers settled well before the edge
`timescale 1ns/1ps

// ************************************************************
// receiver capture register
// ************************************************************
module scop_rx_model
  import scop_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sample_valid,
  input  wire logic [CODE_W-1:0] sample_code,
  output logic      [CODE_W-1:0] rx_word,
  output int                     rx_count
);
  initial rx_word = '0;
  initial rx_count = 0;

  // capture on the edge, never mid-cycle, so the output delay is always met
  always @(posedge sys_clk) begin
    if (sample_valid === 1'b1) begin
      rx_word  <= sample_code;
      rx_count <= rx_count + 1;
    end
  end
endmodule : scop_rx_model

/* verif/test_scop_top.sv */
// self-checking bench for the converter output pipeline
// assumes one 25 MHz clock and the receiver model on the output word
`timescale 1ns/1ps

// ************************************************************
// bench top
// ************************************************************
module test_scop_top;
  import scop_pkg::*;

  logic               sys_clk           = 1'b0;
  logic               rst_n             = 1'b0;
  logic               clk_en            = 1'b1;
  logic               sleep_request     = 1'b0;
  logic [LEVEL_W-1:0] sample_level      = 12'h000;
  logic [LEVEL_W-1:0] ladder_bottom_ref = 12'h100;
  logic [LEVEL_W-1:0] ladder_top_ref    = 12'he00;
  logic [CODE_W-1:0]  sample_code;
  logic               sample_valid;
  logic               low_power;
  logic [CODE_W-1:0]  rx_word;
  int                 rx_count;
  int                 n_mismatch        = 0;
  int                 cmp_count         = 0;

  // free-running clock, never stopped by the bench
  always #20 sys_clk = ~sys_clk;

  scop_top i_scop_top (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sleep_request(sleep_request), .sample_level(sample_level),
    .ladder_bottom_ref(ladder_bottom_ref), .ladder_top_ref(ladder_top_ref),
    .sample_code(sample_code), .sample_valid(sample_valid), .low_power(low_power));

  scop_rx_model i_scop_rx_model (.sys_clk(sys_clk), .sample_valid(sample_valid),
    .sample_code(sample_code), .rx_word(rx_word), .rx_count(rx_count));

  // expected word, own arithmetic: 16 levels a step above the bottom ref
  function automatic logic [CODE_W-1:0] ref_code(input logic [LEVEL_W-1:0] lv);
    if (lv < ladder_bottom_ref) return CODE_ZERO;
    if (lv > ladder_top_ref) return CODE_FULL;
    return CODE_W'((lv - ladder_bottom_ref) >> STEP_SH);
  endfunction : ref_code

  task automatic check_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : check_code

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : check_flag

  // back-to-back levels across both clamps; word must appear three edges later
  task automatic test_stream();
    logic [LEVEL_W-1:0] lv [9];
    logic [CODE_W-1:0]  seen;
    lv = '{12'h050, 12'h100, 12'h110, 12'h1ff, 12'h7a3, 12'hdff, 12'he00, 12'he01, 12'hfff};
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      if (i < 9) sample_level <= lv[i];
      #1;
      if (i >= 3) begin
        check_code(sample_code, ref_code(lv[i-3]));
        check_flag(sample_valid, 1'b1);
      end
      seen = sample_code;
      @(negedge sys_clk);
      check_code(sample_code, seen);
    end
    @(posedge sys_clk);
    #1;
    check_code(rx_word, ref_code(lv[8]));
    $display("test stream done");
  endtask : test_stream

  // stopped converter clock keeps the last word on the pins
  task automatic test_halt();
    logic [CODE_W-1:0] held;
    @(posedge sys_clk);
    sample_level <= 12'h300;
    clk_en       <= 1'b0;
    #1;
    held = sample_code;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      check_code(sample_code, held);
    end
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check_code(sample_code, ref_code(12'h300));
    $display("test halt done");
  endtask : test_halt

  // sleep freezes the word; wake discards the backlog and settles about 1 us
  task automatic test_sleep();
    int n;
    @(posedge sys_clk);
    sleep_request <= 1'b1;
    n = 0;
    while (low_power !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_flag(low_power, 1'b1);
    @(posedge sys_clk);
    sample_level <= 12'h900;
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      check_code(sample_code, ref_code(12'h300));
      check_flag(sample_valid, 1'b0);
    end
    // release on an edge, like every other input
    @(posedge sys_clk);
    sleep_request <= 1'b0;
    n = 0;
    while (low_power !== 1'b0 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_flag(low_power, 1'b0);
    n = 0;
    while (sample_valid !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_flag(n >= 24 && n <= 30, 1'b1);
    check_code(sample_code, ref_code(12'h900));
    $display("test sleep done");
  endtask : test_sleep

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_stream();
    test_halt();
    test_sleep();
    wrap_up();
  end

  // watchdog, far beyond the roughly 85 cycles the tests need
  initial begin
    #(CLK_PERIOD_NS * 2000);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : test_scop_top
